// file: rtl/crsa_core.sv
`timescale 1ns/10ps
module crsa_core
  import crsa_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [3:0] OP,
  input wire logic OP_VALID,
  input wire logic [GSEL_W-1:0] OP_REG,
  input wire logic [GPR_W-1:0] FETCH_ADDR,
  input wire logic BUS_DONE,
  input wire logic [ACC_W-1:0] DATA_IN,
  output logic OP_BUSY,
  output logic [ACC_W-1:0] ACC,
  output logic ACC_CARRY,
  output logic [GPR_W-1:0] ADDR,
  output logic [ACC_W-1:0] DATA_OUT,
  output logic DATA_OE_N,
  output logic RD_N,
  output logic WR_N,
  output logic FETCH_VALID,
  output logic [ACC_W-1:0] FETCH_DATA
);

  // ****************************************
  // storage
  // ****************************************
  logic [ACC_W-1:0] acc_r;                    // accumulator
  logic carry_r;                              // carry or borrow of last add or subtract
  logic [GPR_W-1:0] gpr_r [GPR_N];            // general registers
  logic [ACC_W-1:0] scr_r [SCR_DEPTH];        // scratch data memory
  crsa_state_e state_r;                       // bus sequencer
  logic fetch_r;                              // current read is a fetch
  logic [ACC_W-1:0] fetch_data_r;             // fetched code byte
  logic fetch_valid_r;                        // fetch complete pulse
  logic [GPR_W-1:0] addr_r;                   // external address
  logic [ACC_W-1:0] dout_r;                   // write data
  logic busy_r;                               // external cycle running
  logic rd_n_r;                               // read strobe, low active
  logic wr_n_r;                               // write strobe, low active
  logic oe_n_r;                               // data drive, low active

  // ****************************************
  // helpers
  // ****************************************
  // scratch index from a register, upper bits dropped
  function automatic logic [SCR_AW-1:0] scr_idx(input logic [GPR_W-1:0] g);
    scr_idx = g[SCR_AW-1:0];
  endfunction : scr_idx

  logic idle;                                 // sequencer free
  logic take;                                 // operation accepted
  logic [GPR_W-1:0] sel_gpr;                  // selected register
  logic [ACC_W-1:0] scr_byte;                 // selected scratch byte
  logic [ACC_W:0] add_res;                    // sum with carry
  logic [ACC_W:0] sub_res;                    // difference with borrow

  assign idle = (state_r == CRSA_IDLE);
  assign take = idle && OP_VALID;
  assign sel_gpr = gpr_r[OP_REG];
  assign scr_byte = scr_r[scr_idx(sel_gpr)];
  assign add_res = {1'b0, acc_r} + {1'b0, scr_byte};
  assign sub_res = {1'b0, acc_r} - {1'b0, scr_byte};

  // ****************************************
  // accumulator and carry
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      acc_r <= ACC_RST;
      carry_r <= 1'b0;
    end else if (take) begin
      case (crsa_op_e'(OP))
        CRSA_LDS: begin
          acc_r <= scr_byte;
        end
        CRSA_ADS: begin
          acc_r <= add_res[ACC_W-1:0];
          carry_r <= add_res[ACC_W];
        end
        CRSA_SBS: begin
          acc_r <= sub_res[ACC_W-1:0];
          carry_r <= sub_res[ACC_W];
        end
        CRSA_RDG: begin
          acc_r <= sel_gpr[ACC_W-1:0];
        end
        default: begin
          acc_r <= acc_r;  // other ops leave it
        end
      endcase
    end else if (state_r == CRSA_XRD && BUS_DONE && !fetch_r) begin
      acc_r <= DATA_IN;
    end
  end

  // ****************************************
  // scratch memory writes
  // ****************************************
  // internal scratch array, never on the bus
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < SCR_DEPTH; i++) begin
        scr_r[i] <= ACC_RST;
      end
    end else if (take && crsa_op_e'(OP) == CRSA_STS) begin
      scr_r[scr_idx(sel_gpr)] <= acc_r;
    end
  end

  // ****************************************
  // general registers
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < GPR_N; i++) begin
        gpr_r[i] <= GPR_RST;
      end
    end else if (take) begin
      case (crsa_op_e'(OP))
        CRSA_LDG: begin
          gpr_r[OP_REG] <= {sel_gpr[GPR_W-1:ACC_W], acc_r};
        end
        CRSA_ING: begin
          gpr_r[OP_REG] <= sel_gpr + GPR_ONE;
        end
        CRSA_DEG: begin
          gpr_r[OP_REG] <= sel_gpr - GPR_ONE;
        end
        default: begin
          gpr_r[OP_REG] <= sel_gpr;
        end
      endcase
    end
  end

  // ****************************************
  // external bus sequencer
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_r <= CRSA_IDLE;
      fetch_r <= 1'b0;
      addr_r <= GPR_RST;
      dout_r <= ACC_RST;
      // strobes released, no cycle running
      busy_r <= 1'b0;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      oe_n_r <= 1'b1;
    end else begin
      case (state_r)
        CRSA_IDLE: begin
          if (take) begin
            case (crsa_op_e'(OP))
              CRSA_LDX: begin
                state_r <= CRSA_XRD;
                fetch_r <= 1'b0;
                addr_r <= sel_gpr;
                busy_r <= 1'b1;
                rd_n_r <= 1'b0;
              end
              CRSA_STX: begin
                state_r <= CRSA_XWR;
                addr_r <= sel_gpr;
                dout_r <= acc_r;
                busy_r <= 1'b1;
                wr_n_r <= 1'b0;
                oe_n_r <= 1'b0;
              end
              CRSA_FET: begin
                state_r <= CRSA_XRD;
                fetch_r <= 1'b1;
                addr_r <= FETCH_ADDR;
                busy_r <= 1'b1;
                rd_n_r <= 1'b0;
              end
              // scratch ops stay off the bus
              default: begin
                state_r <= CRSA_IDLE;
              end
            endcase
          end
        end
        CRSA_XRD, CRSA_XWR: begin
          // cycle ends at the edge that sees done
          if (BUS_DONE) begin
            state_r <= CRSA_IDLE;
            busy_r <= 1'b0;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            oe_n_r <= 1'b1;
          end
        end
        // stray state: drop back and release the bus
        default: begin
          state_r <= CRSA_IDLE;
          busy_r <= 1'b0;
          rd_n_r <= 1'b1;
          wr_n_r <= 1'b1;
          oe_n_r <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // fetch result
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fetch_data_r <= ACC_RST;
      fetch_valid_r <= 1'b0;
    end else begin
      fetch_valid_r <= (state_r == CRSA_XRD) && BUS_DONE && fetch_r;
      if ((state_r == CRSA_XRD) && BUS_DONE && fetch_r) begin
        fetch_data_r <= DATA_IN;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign ACC = acc_r;
  assign ACC_CARRY = carry_r;
  assign ADDR = addr_r;
  assign DATA_OUT = dout_r;
  assign FETCH_DATA = fetch_data_r;
  assign FETCH_VALID = fetch_valid_r;
  assign OP_BUSY = busy_r;
  assign RD_N = rd_n_r;
  assign WR_N = wr_n_r;
  assign DATA_OE_N = oe_n_r;

endmodule : crsa_core

// file: rtl/crsa_pkg.sv
package crsa_pkg;
  // ****************************************
  // widths and sizes
  // ****************************************
  localparam int ACC_W = 8;          // accumulator width
  localparam int GPR_W = 12;         // general register width
  localparam int GPR_N = 8;          // number of general registers
  localparam int GSEL_W = 3;         // register select width
  localparam int SCR_AW = 6;         // scratch address width
  localparam int SCR_DEPTH = 64;     // scratch bytes
  localparam logic [ACC_W-1:0] ACC_RST = 8'h00;   // accumulator reset value
  localparam logic [GPR_W-1:0] GPR_RST = 12'h000; // register reset value
  localparam logic [GPR_W-1:0] GPR_ONE = 12'h001; // step for inc and dec

  // ****************************************
  // operation codes
  // ****************************************
  typedef enum logic [3:0] {
    CRSA_NOP = 4'h0,  // no operation
    CRSA_LDS = 4'h1,  // scratch byte to accumulator
    CRSA_STS = 4'h2,  // accumulator to scratch byte
    CRSA_ADS = 4'h3,  // add scratch byte to accumulator
    CRSA_SBS = 4'h4,  // subtract scratch byte from accumulator
    CRSA_LDX = 4'h5,  // external byte to accumulator
    CRSA_STX = 4'h6,  // accumulator to external byte
    CRSA_LDG = 4'h7,  // accumulator to low 8 bits of register
    CRSA_RDG = 4'h8,  // low 8 bits of register to accumulator
    CRSA_ING = 4'h9,  // increment register, 12 bits
    CRSA_DEG = 4'ha,  // decrement register, 12 bits
    CRSA_FET = 4'hb   // instruction fetch from program address
  } crsa_op_e;

  // ****************************************
  // bus sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    CRSA_IDLE = 3'b001,  // waiting for an operation
    CRSA_XRD = 3'b010,   // external read cycle
    CRSA_XWR = 3'b100    // external write cycle
  } crsa_state_e;
endpackage : crsa_pkg

// file: testbench/crsa_assertions.sv
`timescale 1ns/10ps
// watches bus strobes and request timing at the core's pins
module crsa_chk
  import crsa_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [3:0] OP,
  input wire logic OP_VALID,
  input wire logic [GPR_W-1:0] FETCH_ADDR,
  input wire logic BUS_DONE,
  input wire logic OP_BUSY,
  input wire logic [ACC_W-1:0] ACC,
  input wire logic [GPR_W-1:0] ADDR,
  input wire logic [ACC_W-1:0] DATA_OUT,
  input wire logic DATA_OE_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic FETCH_VALID
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // a request of one kind taken at this edge
  sequence s_take(logic [3:0] o);
    OP_VALID && !OP_BUSY && OP == o;
  endsequence
  // an external cycle in progress
  sequence s_cyc;
    !RD_N || !WR_N;
  endsequence
  a_scr_no_bus:
    assert property (OP_VALID && !OP_BUSY && OP inside {CRSA_LDS,
      CRSA_STS, CRSA_ADS, CRSA_SBS} |=> RD_N && WR_N && !OP_BUSY)
    else $error("scratch op reached the bus");
  a_ldx_read:
    assert property (s_take(CRSA_LDX) |=> !RD_N && WR_N && OP_BUSY)
    else $error("external read did not start");
  a_stx_write:
    assert property (s_take(CRSA_STX) |=> !WR_N && DATA_OUT == $past(ACC))
    else $error("external write wrong");
  a_fet_addr:
    assert property (s_take(CRSA_FET) |=> !RD_N && ADDR == $past(FETCH_ADDR))
    else $error("fetch not from external memory");
  a_cycle_hold:
    assert property (s_cyc and !BUS_DONE |=> $stable(ADDR) && $stable(RD_N)
      && $stable(WR_N)) else $error("cycle dropped early");
  a_cycle_end:
    assert property (s_cyc and BUS_DONE |=> RD_N && WR_N && !OP_BUSY)
    else $error("cycle did not end");
  a_busy_strobe:
    assert property (OP_BUSY == (!RD_N || !WR_N))
    else $error("busy and strobes disagree");
  a_oe_write:
    assert property (DATA_OE_N == WR_N && !(!RD_N && !WR_N))
    else $error("data enable wrong");
  a_fetch_pulse:
    assert property (FETCH_VALID |=> !FETCH_VALID)
    else $error("fetch pulse too long");
endmodule : crsa_chk

bind crsa_core crsa_chk u_chk (.CLK(CLK), .RST_N(RST_N), .OP(OP),
  .OP_VALID(OP_VALID), .FETCH_ADDR(FETCH_ADDR), .BUS_DONE(BUS_DONE),
  .OP_BUSY(OP_BUSY), .ACC(ACC), .ADDR(ADDR), .DATA_OUT(DATA_OUT),
  .DATA_OE_N(DATA_OE_N), .RD_N(RD_N), .WR_N(WR_N),
  .FETCH_VALID(FETCH_VALID));

// file: testbench/crsa_mem.sv
`timescale 1ns/10ps
// external memory and i/o, answering promptly and slowly in turn
module crsa_mem
  import crsa_pkg::*;
(
  input wire logic clk,
  input wire logic [GPR_W-1:0] addr,
  input wire logic [ACC_W-1:0] dout,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic done,
  output logic [ACC_W-1:0] din
);
  logic [ACC_W-1:0] ram [2**GPR_W]; // program, data and i/o bytes
  logic [1:0] cnt = 2'h0; // wait states spent
  logic slow = 1'b0; // next cycle waits two extra clocks
  initial begin
    done = 1'b0;
    din = 8'h00;
    for (int i = 0; i < 2**GPR_W; i++) ram[i] = i[7:0] ^ 8'h5a;
  end
  always @(posedge clk) begin
    if ((!rd_n || !wr_n) && !done && cnt != {slow, 1'b0}) begin
      cnt <= cnt + 2'h1;
    end else if ((!rd_n || !wr_n) && !done) begin
      done <= 1'b1;
      cnt <= 2'h0;
      slow <= ~slow;
      if (!rd_n) din <= ram[addr];
      else ram[addr] <= dout;
    end else begin
      // released data lines keep moving
      done <= 1'b0;
      din <= ~din;
    end
  end
endmodule : crsa_mem

// file: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import crsa_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] op = 4'h0;
  logic op_valid = 1'b0;
  logic [GSEL_W-1:0] op_reg = 3'h0;
  logic [GPR_W-1:0] fetch_addr = 12'h000;
  logic bus_done, busy, carry, oe_n, rd_n, wr_n, fvalid;
  logic [ACC_W-1:0] data_in, acc, dout, fdata;
  logic [GPR_W-1:0] addr, last_a; // last_a: address seen on the bus
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  crsa_core dut (.CLK(clk), .RST_N(rst_n), .OP(op), .OP_VALID(op_valid),
    .OP_REG(op_reg), .FETCH_ADDR(fetch_addr), .BUS_DONE(bus_done),
    .DATA_IN(data_in), .OP_BUSY(busy), .ACC(acc), .ACC_CARRY(carry),
    .ADDR(addr), .DATA_OUT(dout), .DATA_OE_N(oe_n), .RD_N(rd_n),
    .WR_N(wr_n), .FETCH_VALID(fvalid), .FETCH_DATA(fdata));
  crsa_mem mem (.clk(clk), .addr(addr), .dout(dout), .rd_n(rd_n),
    .wr_n(wr_n), .done(bus_done), .din(data_in));
  task chk(input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  // one request, held to its edge, then wait out any bus cycle
  task run(input crsa_op_e o, input logic [2:0] r);
    int n;
    @(posedge clk);
    op <= o;
    op_reg <= r;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    last_a = addr;
    n = 0;
    while (busy === 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    // a cycle still open here is a hang, counted as a mismatch
    chk(12'h000, {11'h0, busy});
  endtask : run
  task t_ext;
    run(CRSA_LDX, 3'h0);
    chk(12'h05a, {4'h0, acc});
    chk(12'h000, {11'h0, fvalid});
    run(CRSA_DEG, 3'h1);
    run(CRSA_STX, 3'h1);
    chk(12'hfff, last_a);
    chk(12'h05a, {4'h0, mem.ram[12'hfff]});
    run(CRSA_ING, 3'h1);
    run(CRSA_ING, 3'h1);
    run(CRSA_LDX, 3'h1);
    chk(12'h05b, {4'h0, acc});
    $display("test ext done");
  endtask : t_ext
  task t_scr;
    run(CRSA_DEG, 3'h2);
    run(CRSA_LDG, 3'h2);
    run(CRSA_STS, 3'h2);
    run(CRSA_LDG, 3'h3);
    run(CRSA_LDX, 3'h0);
    run(CRSA_ADS, 3'h2);
    chk(12'h0b5, {4'h0, acc});
    chk(12'h000, {11'h0, carry});
    run(CRSA_SBS, 3'h2);
    run(CRSA_SBS, 3'h2);
    chk(12'h0ff, {4'h0, acc});
    chk(12'h001, {11'h0, carry});
    run(CRSA_LDS, 3'h3);
    chk(12'h05b, {4'h0, acc});
    run(CRSA_STX, 3'h2);
    chk(12'hf5b, last_a);
    run(CRSA_RDG, 3'h1);
    chk(12'h001, {4'h0, acc});
    $display("test scratch done");
  endtask : t_scr
  // top and bottom scratch bytes are distinct, no-op leaves acc
  task t_span;
    run(CRSA_DEG, 3'h4);
    run(CRSA_STS, 3'h4);
    run(CRSA_ING, 3'h4);
    run(CRSA_LDS, 3'h4);
    chk(12'h000, {4'h0, acc});
    run(CRSA_DEG, 3'h4);
    run(CRSA_LDS, 3'h4);
    chk(12'h001, {4'h0, acc});
    run(CRSA_NOP, 3'h4);
    chk(12'h001, {4'h0, acc});
    $display("test span done");
  endtask : t_span
  task t_fet;
    @(posedge clk);
    fetch_addr <= 12'h01b;
    run(CRSA_FET, 3'h0);
    chk(12'h01b, last_a);
    chk(12'h041, {4'h0, fdata});
    chk(12'h001, {11'h0, fvalid});
    $display("test fetch done");
  endtask : t_fet
  task final_report;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_ext();
    t_scr();
    t_span();
    t_fet();
    final_report();
  end
endmodule : tb_top
